// file: hw/slrs_pkg.sv
package slrs_pkg;

	// ==========================================
	// Bus geometry
	localparam int ADDR_W = 12;
	localparam int IDX_W  = ADDR_W - 2;

	// ==========================================
	// Register indices (byte address is four times the index)
	localparam logic [IDX_W-1:0] IDX_CTRL       = 10'h060;
	localparam logic [IDX_W-1:0] IDX_RSTEP_LOW  = 10'h062;
	localparam logic [IDX_W-1:0] IDX_RSTEP_HIGH = 10'h063;
	localparam logic [IDX_W-1:0] IDX_IRQ_STAT   = 10'h068;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK   = 10'h069;
	localparam logic [IDX_W-1:0] IDX_LINK_STAT  = 10'h06c;

	// ==========================================
	// Field positions and reset values
	localparam int CTRL_EN_BIT      = 0;
	localparam int STAT_RSVD_BIT    = 7;
	localparam int STAT_LINK_BIT    = 6;
	localparam int STAT_SYNC_BIT    = 5;
	localparam int STAT_REFERENCE_FLAG_A_BIT = 4;
	localparam int IRQ_W            = 3;
	localparam int IRQ_REFERENCE_FLAG_A      = 0;
	localparam int IRQ_LINK_UP      = 1;
	localparam int IRQ_SYNC_REQ     = 2;
	localparam logic [15:0] RSTEP_RESET = 16'h0001;

	// ==========================================
	// Link timing, in frame clock cycles; the alignment sequence length is in multiframes
	localparam int SYNC_MIN_FRAMES = 4;
	localparam int LMFC_FRAMES     = 32;
	localparam int ILA_MULTIFRAMES = 4;
	localparam logic [2:0] SYNC_LAST = 3'(SYNC_MIN_FRAMES - 1);
	localparam logic [4:0] LMFC_LAST = 5'(LMFC_FRAMES - 1);
	localparam logic [2:0] ILA_LAST  = 3'(ILA_MULTIFRAMES - 1);

	// ==========================================
	// Bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		LS_OFF,
		LS_WAIT_SYNC,
		LS_CGS,
		LS_ILA,
		LS_DATA
	} slrs_link_t;

	typedef struct packed {
		logic [15:0]      rstep;
		logic             en;
		logic             reference_flag_a;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_mask;
		slrs_link_t       link;
		logic [2:0]       sync_cnt;
		logic [2:0]       ila_cnt;
		logic [4:0]       lmfc_cnt;
		logic [15:0]      ramp;
		logic             syncb_s1;
		logic             syncb_s2;
		logic             sysref_s1;
		logic             sysref_s2;
		logic             sysref_s3;
		logic             aw_held;
		logic [IDX_W-1:0] aw_idx;
		logic             w_held;
		logic [7:0]       wbyte;
		logic             wlane0;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             rvalid;
		logic [31:0]      rdata;
		logic [1:0]       rresp;
	} slrs_state_t;

endpackage

// file: hw/slrs_top.sv
// What this block does
// - Sixteen-bit ramp step, low byte then high byte, is the ramp increment.
// - Link bit reads one only after sync, alignment sequence done, data flowing.
// - Sync bit reads zero while waiting for a sync request or during sync; one otherwise.
// - Sync bit follows internal sync state, not the raw request pin.
// - Reference_flag_a bit sets when a reference event shifts the multiframe phase.
// - Reference events causing no phase shift leave the reference_flag_a bit alone.
// - Reference_flag_a bit is set at power-up; software clears it before use.
// - Writing one clears the reference_flag_a bit; writing zero does nothing.
`timescale 1ns/1ps
`default_nettype none

module slrs_top
	import slrs_pkg::*;
(
	// Clock and reset
	input  wire logic               aclk,
	input  wire logic               aresetn,
	// AXI4-Lite write address and data
	input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0]  s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	// Link pins from the receiver
	input  wire logic               sync_req_n,
	input  wire logic               sysref,
	// Transmit side
	output slrs_link_t              tx_phase,
	output logic [15:0]             tx_ramp_sample,
	// Interrupt
	output logic                    irq
);

	// ==========================================
	// State
	slrs_state_t st;
	slrs_state_t next_st;

	logic             do_write;
	logic             wr_ok;
	logic             wr_hit;
	logic             rd_take;
	logic             sync_bit;
	logic             sysref_edge;
	logic             lmfc_wrap;
	logic             reference_flag_a_event;
	logic             reference_flag_a_clear;
	logic             link_up_event;
	logic             sync_req_event;
	logic [7:0]       status_byte;
	logic [IRQ_W-1:0] irq_events;
	logic [IRQ_W-1:0] irq_clear;

	// ==========================================
	// Bus handshakes
	// One write and one read outstanding; ready drops while holding a beat.
	assign s_axi_awready = !st.aw_held && !st.bvalid;
	assign s_axi_wready  = !st.w_held && !st.bvalid;
	assign s_axi_arready = !st.rvalid;
	assign s_axi_bvalid  = st.bvalid;
	assign s_axi_bresp   = st.bresp;
	assign s_axi_rvalid  = st.rvalid;
	assign s_axi_rdata   = st.rdata;
	assign s_axi_rresp   = st.rresp;

	assign do_write = st.aw_held && st.w_held && !st.bvalid;
	assign wr_ok    = do_write && st.wlane0;
	assign rd_take  = s_axi_arvalid && s_axi_arready;
	assign wr_hit   = (st.aw_idx == IDX_CTRL) || (st.aw_idx == IDX_RSTEP_LOW)
		|| (st.aw_idx == IDX_RSTEP_HIGH) || (st.aw_idx == IDX_IRQ_STAT)
		|| (st.aw_idx == IDX_IRQ_MASK) || (st.aw_idx == IDX_LINK_STAT);

	// ==========================================
	// Link events
	// Sync status is the state machine's view, not the pin level
	assign sync_bit = !((st.link == LS_WAIT_SYNC) || (st.link == LS_CGS));
	// Edge detect looks only at the second and third stage
	assign sysref_edge = st.sysref_s2 && !st.sysref_s3;
	assign lmfc_wrap   = (st.lmfc_cnt == LMFC_LAST);
	// Counter already about to wrap means the phase is right: no shift
	assign reference_flag_a_event  = sysref_edge && !lmfc_wrap;
	assign reference_flag_a_clear  = wr_ok && (st.aw_idx == IDX_LINK_STAT)
		&& st.wbyte[STAT_REFERENCE_FLAG_A_BIT];
	assign link_up_event  = (st.link == LS_ILA) && lmfc_wrap && (st.ila_cnt == ILA_LAST);
	assign sync_req_event = (st.link == LS_DATA) && !st.syncb_s2;

	assign irq_events = {sync_req_event, link_up_event, reference_flag_a_event};
	assign irq_clear  = (wr_ok && (st.aw_idx == IDX_IRQ_STAT)) ? st.wbyte[IRQ_W-1:0]
		: '0;

	// Reserved top bit and the out-of-scope low bits read as zero
	assign status_byte = {1'b0, st.link == LS_DATA, sync_bit, st.reference_flag_a, 4'h0};

	// ==========================================
	// Next state
	always_comb begin
		next_st = st;

		// Two-stage synchronisers
		next_st.syncb_s1  = sync_req_n;
		next_st.syncb_s2  = st.syncb_s1;
		next_st.sysref_s1 = sysref;
		next_st.sysref_s2 = st.sysref_s1;
		next_st.sysref_s3 = st.sysref_s2;

		// Write address and data, either order
		if (s_axi_awvalid && s_axi_awready) begin
			next_st.aw_held = 1'b1;
			next_st.aw_idx  = s_axi_awaddr[ADDR_W-1:2];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_st.w_held = 1'b1;
			next_st.wbyte  = s_axi_wdata[7:0];
			next_st.wlane0 = s_axi_wstrb[0];
		end
		if (do_write) begin
			next_st.aw_held = 1'b0;
			next_st.w_held  = 1'b0;
			next_st.bvalid  = 1'b1;
			next_st.bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
			if (wr_ok) begin
				case (st.aw_idx)
					IDX_CTRL: begin
						next_st.en = st.wbyte[CTRL_EN_BIT];
					end
					IDX_RSTEP_LOW: begin
						next_st.rstep[7:0] = st.wbyte;
					end
					IDX_RSTEP_HIGH: begin
						next_st.rstep[15:8] = st.wbyte;
					end
					IDX_IRQ_MASK: begin
						next_st.irq_mask = st.wbyte[IRQ_W-1:0];
					end
					default: begin
					end
				endcase
			end
		end else if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end

		// Read: data captured when the address is taken
		if (rd_take) begin
			next_st.rvalid = 1'b1;
			next_st.rresp  = RESP_OKAY;
			case (s_axi_araddr[ADDR_W-1:2])
				IDX_CTRL:       next_st.rdata = {31'h0, st.en};
				IDX_RSTEP_LOW:  next_st.rdata = {24'h0, st.rstep[7:0]};
				IDX_RSTEP_HIGH: next_st.rdata = {24'h0, st.rstep[15:8]};
				IDX_IRQ_STAT:   next_st.rdata = {29'h0, st.irq_stat};
				IDX_IRQ_MASK:   next_st.rdata = {29'h0, st.irq_mask};
				IDX_LINK_STAT:  next_st.rdata = {24'h0, status_byte};
				default: begin
					next_st.rdata = 32'h0;
					next_st.rresp = RESP_SLVERR;
				end
			endcase
		end else if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end

		// Sticky flags: a set in the same cycle beats the clear
		if (reference_flag_a_event) begin
			next_st.reference_flag_a = 1'b1;
		end else if (reference_flag_a_clear) begin
			next_st.reference_flag_a = 1'b0;
		end
		next_st.irq_stat = (st.irq_stat & ~irq_clear) | irq_events;

		// Multiframe counter, re-phased by a reference edge
		if (sysref_edge) begin
			next_st.lmfc_cnt = 5'h00;
		end else begin
			next_st.lmfc_cnt = lmfc_wrap ? 5'h00 : st.lmfc_cnt + 5'h01;
		end

		// Link sequencing
		case (st.link)
			LS_OFF: begin
				next_st.sync_cnt = 3'h0;
				if (st.en) begin
					next_st.link = LS_WAIT_SYNC;
				end
			end
			LS_WAIT_SYNC: begin
				if (st.syncb_s2) begin
					next_st.sync_cnt = 3'h0;
				end else if (st.sync_cnt == SYNC_LAST) begin
					next_st.link = LS_CGS;
				end else begin
					next_st.sync_cnt = st.sync_cnt + 3'h1;
				end
			end
			LS_CGS: begin
				next_st.ila_cnt = 3'h0;
				// Alignment sequence starts on a multiframe boundary
				if (st.syncb_s2 && lmfc_wrap) begin
					next_st.link = LS_ILA;
				end
			end
			LS_ILA: begin
				if (link_up_event) begin
					next_st.link = LS_DATA;
				end else if (lmfc_wrap) begin
					next_st.ila_cnt = st.ila_cnt + 3'h1;
				end
			end
			LS_DATA: begin
				next_st.ramp = st.ramp + st.rstep;
				if (sync_req_event) begin
					next_st.link     = LS_WAIT_SYNC;
					next_st.sync_cnt = 3'h1;
				end
			end
			default: begin
				next_st.link = LS_OFF;
			end
		endcase
		// Disabling the output tears the link down at once
		if (!st.en) begin
			next_st.link = LS_OFF;
		end
	end

	// ==========================================
	// Registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st          <= '0;
			st.rstep    <= RSTEP_RESET;
			st.reference_flag_a  <= 1'b1;
			st.link     <= LS_OFF;
			st.syncb_s1 <= 1'b1;
			st.syncb_s2 <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign tx_phase       = st.link;
	assign tx_ramp_sample = st.ramp;
	assign irq            = |(st.irq_stat & st.irq_mask);

	// ==========================================
	// Checks
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	ramp_increment_a: assert property (
		st.link == LS_DATA && next_st.link == LS_DATA |=> st.ramp == $past(st.ramp)
			+ $past(st.rstep))
		else $error("ramp did not advance by the step");

	step_reset_a: assert property (
		disable iff (1'b0) !aresetn |=> st.rstep == RSTEP_RESET)
		else $error("ramp step not one after reset");

	reference_flag_a_powerup_a: assert property (
		disable iff (1'b0) !aresetn |=> st.reference_flag_a)
		else $error("reference_flag_a flag not set after reset");

	link_entry_a: assert property (
		$rose(st.link == LS_DATA) |-> $past(st.link) == LS_ILA
			&& $past(st.ila_cnt) == ILA_LAST)
		else $error("link entered data without full alignment sequence");

	sync_wait_a: assert property (
		$rose(st.link == LS_CGS) |-> $past(!st.syncb_s2, 1) && $past(!st.syncb_s2, 4))
		else $error("sync started before four request cycles");

	sync_status_a: assert property (
		st.link == LS_CGS |-> !status_byte[STAT_SYNC_BIT])
		else $error("sync bit high while synchronising");

	reference_flag_a_set_a: assert property (
		reference_flag_a_event |=> st.reference_flag_a)
		else $error("reference_flag_a flag missed a phase shift");

	reference_flag_a_keep_a: assert property (
		sysref_edge && lmfc_wrap && !reference_flag_a_clear |=> $stable(st.reference_flag_a))
		else $error("reference_flag_a flag moved without a phase shift");

	reference_flag_a_clear_a: assert property (
		reference_flag_a_clear && !reference_flag_a_event |=> !st.reference_flag_a)
		else $error("write one did not clear reference_flag_a flag");

	reserved_bit_a: assert property (
		st.rvalid && $past(rd_take) && $past(s_axi_araddr[ADDR_W-1:2]) == IDX_LINK_STAT
			|-> !st.rdata[STAT_RSVD_BIT])
		else $error("reserved status bit read as one");

	link_drop_a: assert property (
		sync_req_event |=> st.link != LS_DATA ##1 st.link != LS_DATA)
		else $error("link bit held after sync request");

	// Step only moves through its own two registers
	step_hold_a: assert property (
		!(wr_ok && (st.aw_idx == IDX_RSTEP_LOW || st.aw_idx == IDX_RSTEP_HIGH))
			|=> $stable(st.rstep))
		else $error("ramp step changed without a write");

	sync_low_a: assert property (
		st.link == LS_WAIT_SYNC |-> !status_byte[STAT_SYNC_BIT])
		else $error("sync bit high while a request is pending");

	link_irq_a: assert property (
		link_up_event |=> st.irq_stat[IRQ_LINK_UP])
		else $error("link up event not latched");

	bresp_hold_a: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");

	rdata_hold_a: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");

	link_up_c: cover property ($rose(st.link == LS_DATA));
	reference_flag_a_c: cover property (reference_flag_a_event ##[1:200] reference_flag_a_clear);
	write_c:   cover property (do_write && wr_hit ##1 st.bvalid);
	resync_c:  cover property (sync_req_event ##[1:400] link_up_event);

endmodule

`default_nettype wire

// file: bench/slrs_rx_model.sv
`timescale 1ns/1ps
`default_nettype none

module slrs_rx_model (
	// Clock
	input  wire logic aclk,
	// Bench commands
	input  wire logic req_sync,
	input  wire logic ref_run,
	// Link pins
	output logic      sync_req_n,
	output logic      sysref
);
	logic [4:0] ref_cnt = 5'h00;

	// ==========================================
	// Request and reference pulses
	// Bench holds req_sync for 8 frames, over the 4 needed
	always_ff @(posedge aclk) begin
		sync_req_n <= !req_sync;
		ref_cnt    <= ref_run ? ref_cnt + 5'h01 : 5'h00;
		sysref     <= ref_run && ref_cnt == 5'h00;
	end
endmodule

`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import slrs_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = 4'hf;
	logic req_sync = 1'b0, ref_run = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, sync_req_n, sysref, irq;
	logic [1:0] bresp, rresp, rsp;
	logic [31:0] rdata, d;
	logic [15:0] ramp, step, r0;
	slrs_link_t phase;
	int failures = 0, checks_done = 0;

	always #20 aclk = !aclk;

	slrs_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .sync_req_n(sync_req_n), .sysref(sysref),
		.tx_phase(phase), .tx_ramp_sample(ramp), .irq(irq));

	slrs_rx_model rx (.aclk(aclk), .req_sync(req_sync), .ref_run(ref_run),
		.sync_req_n(sync_req_n), .sysref(sysref));

	// ==========================================
	// Compare and bus tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_rsp(input logic [1:0] got, input logic [1:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t response %h expected %h", $time, got, exp);
		end
	endtask

	// Ready sampled 1 ns after the edge, once that edge's updates landed
	task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] v);
		int n;
		logic aw_hit, w_hit, b_hit;
		n = 0;
		b_hit = 1'b0;
		awaddr <= {idx, 2'h0};
		wdata <= {24'h0, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b_hit && n < 200) begin
			#1;
			aw_hit = awvalid && awready;
			w_hit = wvalid && wready;
			b_hit = (bvalid === 1'b1);
			rsp = bresp;
			@(posedge aclk);
			n++;
			if (aw_hit) awvalid <= 1'b0;
			if (w_hit) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		if (!b_hit) failures++;
		@(posedge aclk);
	endtask

	task automatic rd(input logic [IDX_W-1:0] idx);
		int n;
		logic ar_hit, r_hit;
		n = 0;
		r_hit = 1'b0;
		araddr <= {idx, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!r_hit && n < 200) begin
			#1;
			ar_hit = arvalid && arready;
			r_hit = (rvalid === 1'b1);
			d = rdata;
			rsp = rresp;
			@(posedge aclk);
			n++;
			if (ar_hit) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		if (!r_hit) failures++;
		@(posedge aclk);
	endtask

	task automatic wait_phase(input slrs_link_t p);
		int n;
		n = 0;
		#1;
		while (phase !== p && n < 600) begin
			@(posedge aclk);
			#1;
			n++;
		end
		if (phase !== p) failures++;
		// Back on a rising edge so the next drive lands there
		@(posedge aclk);
	endtask

	// Expected status byte from the link view the bench believes in
	function automatic logic [31:0] exp_stat(input logic link, input logic sync,
		input logic reference_flag_a);
		exp_stat = 32'h0;
		exp_stat[STAT_LINK_BIT] = link;
		exp_stat[STAT_SYNC_BIT] = sync;
		exp_stat[STAT_REFERENCE_FLAG_A_BIT] = reference_flag_a;
	endfunction

	task automatic close_out();
		if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// ==========================================
	// Watchdog, far above the ~700 cycles the run needs
	initial begin
		#(40 * 20000);
		failures++;
		close_out();
	end

	// ==========================================
	// Main sequence
	initial begin
		void'($urandom(32'hfaea31a7));
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(IDX_RSTEP_LOW);
		chk(d, 32'h1);
		rd(IDX_RSTEP_HIGH);
		chk(d, 32'h0);
		rd(IDX_LINK_STAT);
		chk(d, exp_stat(1'b0, 1'b1, 1'b1));
		wr(IDX_LINK_STAT, 8'hef);
		rd(IDX_LINK_STAT);
		chk(d, exp_stat(1'b0, 1'b1, 1'b1));
		wr(IDX_LINK_STAT, 8'h10);
		rd(IDX_LINK_STAT);
		chk(d, exp_stat(1'b0, 1'b1, 1'b0));
		step = 16'($urandom_range(32'hffff, 32'h1));
		wr(IDX_RSTEP_LOW, step[7:0]);
		wr(IDX_RSTEP_HIGH, step[15:8]);
		rd(IDX_RSTEP_LOW);
		chk(d, {24'h0, step[7:0]});
		rd(IDX_RSTEP_HIGH);
		chk(d, {24'h0, step[15:8]});
		// Low lane strobe off: the write is answered but changes nothing
		wstrb <= 4'he;
		wr(IDX_RSTEP_LOW, ~step[7:0]);
		wstrb <= 4'hf;
		chk_rsp(rsp, RESP_OKAY);
		rd(IDX_RSTEP_LOW);
		chk(d, {24'h0, step[7:0]});
		wr(10'h3ff, 8'h55);
		chk_rsp(rsp, RESP_SLVERR);
		rd(10'h3fe);
		chk_rsp(rsp, RESP_SLVERR);
		wr(IDX_IRQ_MASK, 8'h07);
		wr(IDX_CTRL, 8'h01);
		rd(IDX_LINK_STAT);
		chk(d, exp_stat(1'b0, 1'b0, 1'b0));
		req_sync <= 1'b1;
		repeat (8) @(posedge aclk);
		req_sync <= 1'b0;
		wait_phase(LS_ILA);
		rd(IDX_LINK_STAT);
		chk(d, exp_stat(1'b0, 1'b1, 1'b0));
		wait_phase(LS_DATA);
		#1;
		r0 = ramp;
		@(posedge aclk);
		#1;
		chk({16'h0, ramp - r0}, {16'h0, step});
		@(posedge aclk);
		rd(IDX_LINK_STAT);
		chk(d, exp_stat(1'b1, 1'b1, 1'b0));
		chk({31'h0, irq}, 32'h1);
		rd(IDX_IRQ_STAT);
		chk(d, 32'h2);
		wr(IDX_IRQ_MASK, 8'h00);
		chk({31'h0, irq}, 32'h0);
		wr(IDX_IRQ_MASK, 8'h02);
		wr(IDX_IRQ_STAT, 8'h02);
		chk({31'h0, irq}, 32'h0);
		// First pulses set the phase; later ones at a 32-frame period match it
		ref_run <= 1'b1;
		repeat (70) @(posedge aclk);
		wr(IDX_LINK_STAT, 8'h10);
		repeat (100) @(posedge aclk);
		rd(IDX_LINK_STAT);
		chk(d, exp_stat(1'b1, 1'b1, 1'b0));
		while (sysref !== 1'b1) @(posedge aclk);
		repeat (5) @(posedge aclk);
		ref_run <= 1'b0;
		@(posedge aclk);
		ref_run <= 1'b1;
		repeat (20) @(posedge aclk);
		rd(IDX_LINK_STAT);
		chk(d, exp_stat(1'b1, 1'b1, 1'b1));
		req_sync <= 1'b1;
		repeat (8) @(posedge aclk);
		rd(IDX_LINK_STAT);
		chk(d, exp_stat(1'b0, 1'b0, 1'b1));
		req_sync <= 1'b0;
		wait_phase(LS_DATA);
		rd(IDX_LINK_STAT);
		chk(d, exp_stat(1'b1, 1'b1, 1'b1));
		rd(IDX_IRQ_STAT);
		chk(d, 32'h7);
		chk({31'h0, irq}, 32'h1);
		// Dropping the enable tears the link down at once
		wr(IDX_CTRL, 8'h00);
		wait_phase(LS_OFF);
		rd(IDX_LINK_STAT);
		chk(d, exp_stat(1'b0, 1'b1, 1'b1));
		close_out();
	end
endmodule

`default_nettype wire
